// *** hdl/arsi_core.sv ***
// Result capture, status mirror, interrupt request and trigger start
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module arsi_core
   import arsi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   input wire logic [NUM_TRIG-1:0] i_trig,
   input wire logic i_conv_done,
   input wire logic [CH_W-1:0] i_conv_chan,
   input wire logic [VAL_W-1:0] i_conv_value,
   output logic o_conv_start,
   output logic o_burst,
   output logic o_irq
);

   // Channel index of a result register address, and whether it is one
   function automatic logic is_chan(input logic [ADDR_W-1:0] a);
      return (a >= CHAN0_RESULT_ADDR) && (a <= CHAN7_RESULT_ADDR) &&
             (a[1:0] == 2'b00);
   endfunction

   function automatic logic [CH_W-1:0] chan_of(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] off;
      off = (a - CHAN0_RESULT_ADDR) / WORD_STRIDE;
      return off[CH_W-1:0];
   endfunction

   arsi_result_s [NUM_CH-1:0] res_q, res_d;
   arsi_result_s gres_q, gres_d;
   logic [CH_W-1:0] gchan_q, gchan_d;
   logic [NUM_CH-1:0] chan_irq_mask_q, chan_irq_mask_d;
   logic global_done_irq_en_q, global_done_irq_en_d;
   logic [DATA_W-1:0] conv_control_q, conv_control_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic irq_q, irq_d;
   logic start_q, start_d;
   logic [NUM_TRIG-1:0] trig_s1_q, trig_s2_q, trig_s3_q;
   logic conv_irq_flag;
   logic [DATA_W-1:0] conv_status;
   logic burst;
   logic [CTL_START_W-1:0] start_code;
   logic edge_fall;
   logic sel_now, sel_prev, trig_hit;
   logic ctl_wr;
   arsi_conv_s conv;

   assign conv.valid = i_conv_done;
   assign conv.chan = i_conv_chan;
   assign conv.value = i_conv_value;
   assign burst = conv_control_q[CTL_BURST_BIT];
   assign start_code = conv_control_q[CTL_START_LSB +: CTL_START_W];
   assign edge_fall = conv_control_q[CTL_EDGE_BIT];
   assign ctl_wr = i_wr && (i_addr == CONV_CONTROL_ADDR);

   // Trigger pins cross into this clock: two stages, then an edge stage
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         trig_s1_q <= '0;
         trig_s2_q <= '0;
         trig_s3_q <= '0;
      end else begin
         trig_s1_q <= i_trig;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end

   always_comb begin
      logic [CH_W-1:0] idx;
      idx = '0;
      sel_now = 1'b0;
      sel_prev = 1'b0;
      if (start_code >= START_TRIG_FIRST) begin
         idx = start_code - START_TRIG_FIRST;
         sel_now = trig_s2_q[idx];
         sel_prev = trig_s3_q[idx];
      end
      trig_hit = edge_fall ? (sel_prev && !sel_now) : (!sel_prev && sel_now);
   end

   // Interrupt flag and status image
   always_comb begin
      logic [NUM_CH-1:0] dn, ov;
      for (int i = 0; i < NUM_CH; i++) begin
         dn[i] = res_q[i].done;
         ov[i] = res_q[i].overrun;
      end
      conv_irq_flag = |(dn & chan_irq_mask_q);
      // Global completion only adds to the request when its enable is set
      irq_d = conv_irq_flag || (global_done_irq_en_q && gres_q.done);
      conv_status = '0;
      conv_status[ST_DONE_LSB +: NUM_CH] = dn;
      conv_status[ST_OVR_LSB +: NUM_CH] = ov;
      conv_status[ST_IRQ_BIT] = conv_irq_flag;
   end

   // Register state and read mux
   always_comb begin
      res_d = res_q;
      gres_d = gres_q;
      gchan_d = gchan_q;
      chan_irq_mask_d = chan_irq_mask_q;
      global_done_irq_en_d = global_done_irq_en_q;
      conv_control_d = conv_control_q;
      rdata_d = '0;
      start_d = 1'b0;

      if (i_rd) begin
         if (is_chan(i_addr)) begin
            rdata_d[VAL_LSB +: VAL_W] = res_q[chan_of(i_addr)].value;
            rdata_d[OVR_BIT] = res_q[chan_of(i_addr)].overrun;
            rdata_d[DONE_BIT] = res_q[chan_of(i_addr)].done;
            res_d[chan_of(i_addr)].done = 1'b0;
            res_d[chan_of(i_addr)].overrun = 1'b0;
         end else begin
            unique case (i_addr)
               CONV_CONTROL_ADDR: rdata_d = conv_control_q;
               GLOBAL_RESULT_ADDR: begin
                  rdata_d[VAL_LSB +: VAL_W] = gres_q.value;
                  rdata_d[GCHN_LSB +: CH_W] = gchan_q;
                  rdata_d[OVR_BIT] = gres_q.overrun;
                  rdata_d[DONE_BIT] = gres_q.done;
                  gres_d.done = 1'b0;
               end
               IRQ_ENABLE_ADDR: begin
                  rdata_d[NUM_CH-1:0] = chan_irq_mask_q;
                  rdata_d[GIEN_BIT] = global_done_irq_en_q;
               end
               CONV_STATUS_ADDR: rdata_d = conv_status;
               default: rdata_d = '0;
            endcase
         end
      end

      if (i_wr) begin
         if (i_addr == IRQ_ENABLE_ADDR) begin
            chan_irq_mask_d = i_wdata[NUM_CH-1:0];
            global_done_irq_en_d = i_wdata[GIEN_BIT];
         end
         if (ctl_wr) begin
            conv_control_d = i_wdata;
            gres_d.done = 1'b0;
         end
      end

      // Start now on control write, or on the selected trigger edge when burst is off
      if (ctl_wr && (i_wdata[CTL_START_LSB +: CTL_START_W] == START_NOW)) begin
         start_d = 1'b1;
      end
      if (!burst && (start_code >= START_TRIG_FIRST) && trig_hit) begin
         start_d = 1'b1;
      end

      // Completion last, so it wins over a read clear in the same cycle
      if (conv.valid) begin
         if (burst && res_q[conv.chan].done) begin
            res_d[conv.chan].overrun = 1'b1;
         end else begin
            res_d[conv.chan].overrun = 1'b0;
         end
         res_d[conv.chan].value = conv.value;
         res_d[conv.chan].done = 1'b1;
         gres_d.overrun = burst && gres_q.done;
         gres_d.value = conv.value;
         gres_d.done = 1'b1;
         gchan_d = conv.chan;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         res_q <= '0;
         gres_q <= '0;
         gchan_q <= '0;
         chan_irq_mask_q <= CHAN_MASK_RST;
         global_done_irq_en_q <= GIEN_RST;
         conv_control_q <= CTL_RST;
         rdata_q <= '0;
         irq_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         res_q <= res_d;
         gres_q <= gres_d;
         gchan_q <= gchan_d;
         chan_irq_mask_q <= chan_irq_mask_d;
         global_done_irq_en_q <= global_done_irq_en_d;
         conv_control_q <= conv_control_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         start_q <= start_d;
      end
   end

   // Burst mode is latched in the control word; o_burst has its own flop, loaded from the next control value
   logic burst_q;
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         burst_q <= 1'b0;
      end else begin
         burst_q <= conv_control_d[CTL_BURST_BIT];
      end
   end

   assign o_rdata = rdata_q;
   assign o_irq = irq_q;
   assign o_conv_start = start_q;
   assign o_burst = burst_q;
endmodule

// *** shared/arsi_pkg.sv ***
// Package: register map, field layout and types of the converter result block
package arsi_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int NUM_CH = 8;
   localparam int VAL_W = 10;
   localparam int CH_W = 3;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] CONV_CONTROL_ADDR = 32'h4001_c000;
   localparam logic [ADDR_W-1:0] GLOBAL_RESULT_ADDR = 32'h4001_c004;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 32'h4001_c00c;
   localparam logic [ADDR_W-1:0] CHAN0_RESULT_ADDR = 32'h4001_c010;
   localparam logic [ADDR_W-1:0] CHAN7_RESULT_ADDR = 32'h4001_c02c;
   localparam logic [ADDR_W-1:0] CONV_STATUS_ADDR = 32'h4001_c030;
   localparam logic [ADDR_W-1:0] WORD_STRIDE = 32'h0000_0004;

   // Field positions
   localparam int VAL_LSB = 6;
   localparam int GCHN_LSB = 24;
   localparam int OVR_BIT = 30;
   localparam int DONE_BIT = 31;
   localparam int GIEN_BIT = 8;
   localparam int ST_DONE_LSB = 0;
   localparam int ST_OVR_LSB = 8;
   localparam int ST_IRQ_BIT = 16;
   localparam int CTL_BURST_BIT = 16;
   localparam int CTL_START_LSB = 24;
   localparam int CTL_START_W = 3;
   localparam int CTL_EDGE_BIT = 27;

   // Reset values
   localparam logic [NUM_CH-1:0] CHAN_MASK_RST = 8'h00;
   localparam logic GIEN_RST = 1'b1;
   localparam logic [DATA_W-1:0] CTL_RST = 32'h0000_0000;

   // Start field codes: none, start now, and the first hardware trigger
   localparam logic [CTL_START_W-1:0] START_NONE = 3'h0;
   localparam logic [CTL_START_W-1:0] START_NOW = 3'h1;
   localparam logic [CTL_START_W-1:0] START_TRIG_FIRST = 3'h2;
   localparam int NUM_TRIG = 6;

   typedef struct packed {
      logic done;
      logic overrun;
      logic [VAL_W-1:0] value;
   } arsi_result_s;

   typedef struct packed {
      logic valid;
      logic [CH_W-1:0] chan;
      logic [VAL_W-1:0] value;
   } arsi_conv_s;
endpackage

// *** dv/arsi_core_props.sv ***
// Bound checker for the converter result block
`timescale 1ns/1ps
module arsi_core_props
   import arsi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic i_conv_done,
   input wire logic o_conv_start,
   input wire logic o_burst,
   input wire logic o_irq
);
   logic [NUM_CH-1:0] mask_q;
   logic [CH_W-1:0] ch_q, ch_qq;
   logic [ADDR_W-1:0] off;
   logic is_ch, is_st;
   assign off = i_addr - CHAN0_RESULT_ADDR;
   assign is_ch = i_rd && off <= 32'h1c;
   assign is_st = i_rd && i_addr == CONV_STATUS_ADDR;
   // Shadow mask lets a status read be judged without the design state
   always_ff @(posedge i_clk) begin
      if (!i_reset_n)
         mask_q <= '0;
      else if (i_wr && i_addr == IRQ_ENABLE_ADDR)
         mask_q <= i_wdata[7:0];
      ch_q <= off[4:2];
      ch_qq <= ch_q;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_ien_spare_zero: assert property (
      i_rd && i_addr == IRQ_ENABLE_ADDR |=> o_rdata[31:9] == 23'h0)
      else $error("enable spare bits set");
   a_stat_spare_zero: assert property (
      is_st |=> o_rdata[31:17] == 15'h0) else $error("status spare bits set");
   a_stat_irq_or: assert property (
      is_st |=> o_rdata[16] == |(o_rdata[7:0] & mask_q))
      else $error("status irq flag wrong");
   a_res_spare_zero: assert property (
      is_ch |=> o_rdata[29:16] == 14'h0 && o_rdata[5:0] == 6'h0)
      else $error("result spare bits set");
   a_read_clears_flags: assert property (
      (is_ch && !i_conv_done) ##1 (is_st && !i_conv_done)
      |=> !o_rdata[ch_qq] && !o_rdata[8 + ch_qq]) else $error("flags kept");
   a_start_one_cycle: assert property (
      o_conv_start |=> !o_conv_start) else $error("start too long");
   a_irq_rise_cause: assert property (
      $rose(o_irq) |-> $past(i_conv_done, 2) || $past(i_wr, 2) || $past(i_wr))
      else $error("irq rose without cause");
   a_irq_fall_cause: assert property (
      $fell(o_irq) |-> $past(i_rd, 2) || $past(i_wr, 2) || $past(i_wr))
      else $error("irq fell without access");
   a_burst_from_ctl: assert property (
      i_wr && i_addr == CONV_CONTROL_ADDR |=> o_burst == $past(i_wdata[16]))
      else $error("burst not taken");
endmodule
bind arsi_core arsi_core_props arsi_core_props_i (.i_clk, .i_reset_n,
   .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_conv_done, .o_conv_start,
   .o_burst, .o_irq);

// *** dv/testbench.sv ***
// Self-checking bench for the converter result block
`timescale 1ns/1ps
module testbench
   import arsi_pkg::*;
;
   logic i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic i_conv_done = 1'b0, o_conv_start, o_burst, o_irq;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0, o_rdata;
   logic [NUM_TRIG-1:0] i_trig = '0;
   logic [CH_W-1:0] i_conv_chan = '0;
   logic [VAL_W-1:0] i_conv_value = '0;
   logic [ADDR_W-1:0] ch0 = CHAN0_RESULT_ADDR;
   int miscompares = 0, n_compared = 0, cycles = 0;
   always #20 i_clk = ~i_clk;
   arsi_core arsi_core_i (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr,
      .i_rd, .o_rdata, .i_trig, .i_conv_done, .i_conv_chan, .i_conv_value,
      .o_conv_start, .o_burst, .o_irq);
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [31:0] a, d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   // Strobe drops on the taking edge, so calls may follow back to back
   task automatic rd(input logic [31:0] a, exp, input string nm);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(nm, o_rdata, exp);
   endtask
   task automatic conv(input logic [2:0] c, input logic [9:0] v);
      i_conv_done <= 1'b1;
      i_conv_chan <= c;
      i_conv_value <= v;
      @(posedge i_clk);
      i_conv_done <= 1'b0;
      #1;
   endtask
   task automatic wstart(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (8) begin
         @(posedge i_clk);
         #1 seen = seen | o_conv_start;
      end
      chk("start", {31'h0, seen}, {31'h0, exp});
   endtask
   task automatic results();
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end
   initial begin
      repeat (6) @(posedge i_clk);
      i_reset_n <= 1'b1;
      #1;
      rd(IRQ_ENABLE_ADDR, 32'h0000_0100, "ien");
      rd(CONV_STATUS_ADDR, 32'h0, "stat");
      rd(32'h4001_c040, 32'h0, "spare");
      wr(IRQ_ENABLE_ADDR, 32'hffff_fe04);
      rd(IRQ_ENABLE_ADDR, 32'h0000_0004, "ien");
      conv(3'h2, 10'h3ff);
      rd(CONV_STATUS_ADDR, 32'h0001_0004, "stat");
      chk("irq", o_irq, 1'b1);
      rd(ch0 + 32'h8, 32'h8000_ffc0, "ch2");
      rd(CONV_STATUS_ADDR, 32'h0, "stat");
      chk("irq", o_irq, 1'b0);
      conv(3'h3, 10'h155);
      rd(CONV_STATUS_ADDR, 32'h0000_0008, "stat");
      rd(ch0 + 32'hc, 32'h8000_5540, "ch3");
      wr(CONV_CONTROL_ADDR, 32'h0001_0000);
      chk("burst", o_burst, 1'b1);
      rd(CONV_CONTROL_ADDR, 32'h0001_0000, "ctl");
      conv(3'h5, 10'h001);
      conv(3'h5, 10'h002);
      rd(CONV_STATUS_ADDR, 32'h0000_2020, "stat");
      rd(ch0 + 32'h14, 32'hc000_0080, "ch5");
      rd(ch0 + 32'h14, 32'h0000_0080, "ch5");
      conv(3'h1, 10'h010);
      rd(ch0 + 32'h4, 32'h8000_0400, "ch1");
      i_conv_done <= 1'b1;
      i_conv_value <= 10'h020;
      rd(ch0 + 32'h4, 32'h0000_0400, "ch1");
      i_conv_done <= 1'b0;
      rd(CONV_STATUS_ADDR, 32'h0000_0002, "stat");
      rd(ch0 + 32'h4, 32'h8000_0800, "ch1");
      wr(CONV_CONTROL_ADDR, 32'h0);
      wr(IRQ_ENABLE_ADDR, 32'h0000_0100);
      conv(3'h0, 10'h000);
      rd(GLOBAL_RESULT_ADDR, 32'h8000_0000, "glob");
      chk("irq", o_irq, 1'b1);
      rd(CONV_STATUS_ADDR, 32'h0000_0001, "stat");
      chk("irq", o_irq, 1'b0);
      conv(3'h1, 10'h3ff);
      wr(CONV_CONTROL_ADDR, 32'h0);
      rd(GLOBAL_RESULT_ADDR, 32'h0100_ffc0, "glob");
      for (int c = 2; c < 8; c++) begin
         wr(CONV_CONTROL_ADDR, 32'(c) << 24);
         i_trig[c-2] <= 1'b1;
         wstart(1'b1);
         i_trig[c-2] <= 1'b0;
         wstart(1'b0);
      end
      wr(CONV_CONTROL_ADDR, 32'h0100_0000);
      chk("start", o_conv_start, 1'b1);
      chk("burst", o_burst, 1'b0);
      wr(CONV_CONTROL_ADDR, 32'h0a00_0000);
      i_trig[0] <= 1'b1;
      wstart(1'b0);
      i_trig[0] <= 1'b0;
      wstart(1'b1);
      wr(CONV_CONTROL_ADDR, 32'h0201_0000);
      i_trig[0] <= 1'b1;
      wstart(1'b0);
      results();
   end
endmodule
